// ===== hw/col_capture_defs.svh
// Constants for the column data capture block.
// Assumes inclusion by the design file only.
`ifndef COL_CAPTURE_DEFS_SVH
`define COL_CAPTURE_DEFS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_COL_SEL 8'h08
`define OFS_COL_READ 8'h0c
// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define CTRL_DIR_BIT 0
`define CTRL_POL_BIT 1
`define CTRL_INV_LO_BIT 2
`define CTRL_INV_HI_BIT 3
`define CTRL_HOLD_BIT 4
`define CTRL_RESET 5'h01
// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define STAT_CNT_LSB 0
`define STAT_STATE_LSB 8
`define STAT_OVF_BIT 12
// ----------------------------------------------------------------
// Shift clock counts after the start pulse
// ----------------------------------------------------------------
`define NEXT_START_CLK 7'd80
`define HALT_CLK 7'd82
`endif

// ===== hw/col_capture_pkg.sv
// Types shared by the column data capture block.
// Assumes the defs header sits beside it.
package col_capture_pkg;
   // Shift state, Gray coded along idle, run, halt.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_HALT = 2'b11
   } shift_state_t;
   // Six 6-bit dots, dot 0 in the low bits.
   typedef logic [5:0][5:0] pixel_word_t;
   // One captured word with its register word position.
   typedef struct packed {
      logic [6:0] pos;
      pixel_word_t dots;
   } capture_entry_t;
endpackage

// ===== hw/col_capture.sv
// Column data capture front end and its data path FIFO.
// Assumes AHB-Lite with one slave, and pins from a foreign clock domain.
`timescale 1ns/1ps
`include "col_capture_defs.svh"

// ----------------------------------------------------------------
// Synchronous FIFO with valid and ready on both sides
// ----------------------------------------------------------------
module capture_fifo #(
   parameter int WIDTH = 43,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];  // Storage words.
   logic [AW:0] wr_reg;  // Write pointer with wrap bit.
   logic [AW:0] rd_reg;  // Read pointer with wrap bit.
   logic push;
   logic pop;

   assign in_ready = (wr_reg[AW] == rd_reg[AW]) || (wr_reg[AW-1:0] != rd_reg[AW-1:0]);
   assign out_valid = (wr_reg != rd_reg);
   assign out_data = mem[rd_reg[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Storage write; no reset needed on the data itself.
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_reg[AW-1:0]] <= in_data;
      end
   end

   // Pointer update.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= rd_reg + 1'b1;
         end
      end
   end
endmodule

// ----------------------------------------------------------------
// Capture top level
// ----------------------------------------------------------------
module col_capture
   import col_capture_pkg::*;
#(
   parameter int NUM_OUT = 480,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hsel,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic shift_clk,
   input wire logic line_latch_strobe,
   input wire logic [35:0] pixel_data,
   input wire logic right_start_pulse_in,
   output logic right_start_pulse_out,
   output logic right_start_pulse_oe,
   input wire logic left_start_pulse_in,
   output logic left_start_pulse_out,
   output logic left_start_pulse_oe,
   output logic [NUM_OUT-1:0][5:0] column_outputs,
   output logic [NUM_OUT-1:0] column_upper_set
);
   localparam int WORDS = NUM_OUT / 6;
   localparam int SW = 40;  // Synchronised pin vector width.

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [SW-1:0] s1_reg, s2_reg, s3_reg;  // Three flop chain.
   logic [SW-1:0] lvl_reg;  // Accepted level once stages 2 and 3 agree.
   logic sclk_d_reg, stb_d_reg;  // Previous accepted clock and strobe.
   logic sclk_rise, stb_rise, stb_fall;
   logic start_in;
   pixel_word_t pin_word;

   // Chain and glitch filter; stage one feeds stage two only.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         lvl_reg <= '0;
         sclk_d_reg <= 1'b0;
         stb_d_reg <= 1'b0;
      end else begin
         s1_reg <= {pixel_data, shift_clk, line_latch_strobe, right_start_pulse_in, left_start_pulse_in};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         lvl_reg <= (s2_reg & ~(s2_reg ^ s3_reg)) | (lvl_reg & (s2_reg ^ s3_reg));
         sclk_d_reg <= lvl_reg[3];
         stb_d_reg <= lvl_reg[2];
      end
   end

   assign sclk_rise = lvl_reg[3] && !sclk_d_reg;
   assign stb_rise = lvl_reg[2] && !stb_d_reg;
   assign stb_fall = !lvl_reg[2] && stb_d_reg;
   assign pin_word = lvl_reg[39:4];

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   logic [4:0] ctrl_reg;  // Direction, polarity, inversions, drain hold.
   logic [8:0] col_sel_reg;  // Column chosen for read-back.
   logic ovf_reg;  // Sticky: a capture found the FIFO full.
   logic dir, output_polarity_select;
   assign dir = ctrl_reg[`CTRL_DIR_BIT];
   assign output_polarity_select = ctrl_reg[`CTRL_POL_BIT];
   // The selected start input; the other pin is our output.
   assign start_in = dir ? lvl_reg[1] : lvl_reg[0];

   // ----------------------------------------------------------------
   // Shift state
   // ----------------------------------------------------------------
   shift_state_t state_reg;
   logic [6:0] cnt_reg;  // Shift clocks since the start pulse.
   logic [6:0] cnt_next;
   logic next_start_reg;  // Start pulse for the neighbour.
   capture_entry_t push_entry_reg;
   logic push_valid_reg;  // One-cycle push into the FIFO.
   logic fifo_in_ready;
   pixel_word_t inv_word;
   assign cnt_next = cnt_reg + 7'd1;

   // Group inversion applied before storage.
   always_comb begin
      for (int d = 0; d < 6; d++) begin
         inv_word[d] = pin_word[d] ^ {6{ctrl_reg[d < 3 ? `CTRL_INV_LO_BIT : `CTRL_INV_HI_BIT]}};
      end
   end

   // Start, count, neighbour pulse and halt; the strobe wins.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         cnt_reg <= '0;
         next_start_reg <= 1'b0;
         push_valid_reg <= 1'b0;
         push_entry_reg <= '0;
      end else begin
         push_valid_reg <= 1'b0;
         if (stb_rise) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
            next_start_reg <= 1'b0;
         end else if (sclk_rise) begin
            unique case (state_reg)
               ST_IDLE: begin
                  if (start_in) begin
                     state_reg <= ST_RUN;
                     cnt_reg <= '0;
                     push_valid_reg <= 1'b1;
                     push_entry_reg <= '{pos: 7'd0, dots: inv_word};
                  end
               end
               ST_RUN: begin
                  cnt_reg <= cnt_next;
                  next_start_reg <= (cnt_next == `NEXT_START_CLK);
                  if (cnt_next < 7'(WORDS)) begin
                     push_valid_reg <= 1'b1;
                     push_entry_reg <= '{pos: cnt_next, dots: inv_word};
                  end
                  if (cnt_next == `HALT_CLK) begin
                     state_reg <= ST_HALT;
                  end
               end
               ST_HALT: begin
                  next_start_reg <= 1'b0;
               end
            endcase
         end
      end
   end

   // Start pulse pins: direction sets which one we drive.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         right_start_pulse_out <= 1'b0;
         right_start_pulse_oe <= 1'b0;
         left_start_pulse_out <= 1'b0;
         left_start_pulse_oe <= 1'b1;
      end else begin
         right_start_pulse_oe <= !dir;
         left_start_pulse_oe <= dir;
         right_start_pulse_out <= !dir && next_start_reg;
         left_start_pulse_out <= dir && next_start_reg;
      end
   end

   // ----------------------------------------------------------------
   // FIFO between capture and the data register
   // ----------------------------------------------------------------
   capture_entry_t pop_entry;
   logic pop_valid, pop_ready;
   // Software may hold the drain so that the FIFO can be seen to fill.
   assign pop_ready = !ctrl_reg[`CTRL_HOLD_BIT];

   capture_fifo #(.WIDTH($bits(capture_entry_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .in_data(push_entry_reg),
      .in_valid(push_valid_reg),
      .in_ready(fifo_in_ready),
      .out_data(pop_entry),
      .out_valid(pop_valid),
      .out_ready(pop_ready)
   );

   // ----------------------------------------------------------------
   // Data register, latch and output stage
   // ----------------------------------------------------------------
   logic [NUM_OUT-1:0][5:0] data_reg;
   logic [NUM_OUT-1:0][5:0] latch_reg;
   logic copy_pend_reg, apply_pend_reg;
   logic apply_fire;

   // Six consecutive positions per word, mirrored for direction low.
   always_ff @(posedge clk_sys) begin
      if (pop_valid && pop_ready) begin
         for (int d = 0; d < 6; d++) begin
            if (dir) begin
               data_reg[6 * pop_entry.pos + d] <= pop_entry.dots[d];
            end else begin
               data_reg[NUM_OUT - 1 - 6 * pop_entry.pos - d] <= pop_entry.dots[d];
            end
         end
      end
   end

   // The copy waits for the FIFO to drain so no word of the line is lost.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         copy_pend_reg <= 1'b0;
         apply_pend_reg <= 1'b0;
      end else begin
         if (stb_rise) begin
            copy_pend_reg <= 1'b1;
         end else if (!pop_valid) begin
            copy_pend_reg <= 1'b0;
         end
         if (stb_fall) begin
            apply_pend_reg <= 1'b1;
         end else if (apply_fire) begin
            apply_pend_reg <= 1'b0;
         end
      end
   end

   assign apply_fire = apply_pend_reg && !copy_pend_reg;

   // Latch copy.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         latch_reg <= '0;
      end else if (copy_pend_reg && !pop_valid) begin
         latch_reg <= data_reg;
      end
   end

   // Output codes and reference set per column, odd outputs at even index.
   genvar g;
   generate
      for (g = 0; g < NUM_OUT; g++) begin : g_col
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               column_outputs[g] <= '0;
               column_upper_set[g] <= 1'b0;
            end else if (apply_fire) begin
               column_outputs[g] <= latch_reg[g];
               column_upper_set[g] <= ((g % 2) == 0) ? !output_polarity_select : output_polarity_select;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // AHB-Lite slave, zero wait states
   // ----------------------------------------------------------------
   logic ap_wr_reg, ap_rd_reg;  // Data phase pending.
   logic [7:0] ap_addr_reg;
   logic take;
   assign take = hsel && hready && htrans[1];

   // Address phase capture.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ap_wr_reg <= 1'b0;
         ap_rd_reg <= 1'b0;
         ap_addr_reg <= '0;
      end else begin
         ap_wr_reg <= take && hwrite;
         ap_rd_reg <= take && !hwrite;
         if (take) begin
            ap_addr_reg <= haddr[7:0];
         end
      end
   end

   // Register writes; overflow set wins over its clear.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= `CTRL_RESET;
         col_sel_reg <= '0;
         ovf_reg <= 1'b0;
      end else begin
         if (ap_wr_reg && ap_addr_reg == `OFS_CTRL) begin
            ctrl_reg <= hwdata[4:0];
         end
         if (ap_wr_reg && ap_addr_reg == `OFS_COL_SEL) begin
            col_sel_reg <= hwdata[8:0];
         end
         if (push_valid_reg && !fifo_in_ready) begin
            ovf_reg <= 1'b1;
         end else if (ap_wr_reg && ap_addr_reg == `OFS_STATUS && hwdata[`STAT_OVF_BIT]) begin
            ovf_reg <= 1'b0;
         end
      end
   end

   // Read data is registered at the address phase edge.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= '0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= '0;
         if (take && !hwrite) begin
            unique case (haddr[7:0])
               `OFS_CTRL: hrdata <= {27'h0, ctrl_reg};
               `OFS_STATUS: hrdata <= {19'h0, ovf_reg, 2'h0, state_reg, 1'b0, cnt_reg};
               `OFS_COL_SEL: hrdata <= {23'h0, col_sel_reg};
               `OFS_COL_READ: hrdata <= (col_sel_reg < 9'(NUM_OUT)) ?
                  {25'h0, column_upper_set[col_sel_reg], column_outputs[col_sel_reg]} : 32'h0;
               default: hrdata <= 32'h0;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_next_at_eighty: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_reg == ST_RUN && sclk_rise && !stb_rise && cnt_reg == 7'd79) |=> next_start_reg)
      else $error("neighbour start missing at clock 80");
   a_next_one_clk: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (next_start_reg && sclk_rise) |=> !next_start_reg)
      else $error("neighbour start longer than one shift clock");
   a_halt_after_82: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_reg == ST_RUN && sclk_rise && !stb_rise && cnt_reg == 7'd81) |=> state_reg == ST_HALT)
      else $error("capture did not halt after 82 clocks");
   a_strobe_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
      stb_rise |=> (state_reg == ST_IDLE && cnt_reg == 7'd0 && !next_start_reg))
      else $error("strobe did not clear shift state");
   a_start_begins: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_reg == ST_IDLE && sclk_rise && start_in && !stb_rise) |=> (state_reg == ST_RUN && push_valid_reg))
      else $error("start pulse did not begin capture");
   a_oe_follows_dir: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ##1 (left_start_pulse_oe == $past(dir) && right_start_pulse_oe == !$past(dir)))
      else $error("start pin drive does not follow direction");
   a_polarity_sets: assert property (@(posedge clk_sys) disable iff (!rst_n)
      apply_fire |=> (column_upper_set[0] == !$past(output_polarity_select) && column_upper_set[1] == $past(output_polarity_select)))
      else $error("reference set wrong for polarity");
   a_copy_to_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
      apply_fire |=> column_outputs == $past(latch_reg))
      else $error("outputs not loaded from latch");
   a_halt_no_push: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_reg == ST_HALT) |=> !push_valid_reg)
      else $error("capture while halted");
endmodule

// ===== sim/pixel_source.sv
// Timing controller model: shift clock, pixel words, start pulse and line strobe.
// Assumes a 200 MHz clk_sys; every clock, strobe and start level is held at least 6 system cycles.
`timescale 1ns/1ps
module pixel_source (
   input wire logic clk_sys,
   input wire logic dir,
   output logic shift_clk,
   output logic line_latch_strobe,
   output logic [35:0] pixel_data,
   output logic start_right,
   output logic start_left
);
   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   // All pins idle low at time zero.
   initial begin
      shift_clk = 1'b0;
      line_latch_strobe = 1'b0;
      pixel_data = 36'h0;
      start_right = 1'b0;
      start_left = 1'b0;
   end

   // Waits a number of system cycles.
   task automatic hold_cycles(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // One shift clock period carrying word w; the start pulse goes out on the input side.
   task automatic shift_word(input logic [35:0] w, input logic start);
      pixel_data <= w;
      start_right <= dir & start;
      start_left <= ~dir & start;
      hold_cycles(6);
      shift_clk <= 1'b1;
      hold_cycles(6);
      shift_clk <= 1'b0;
      // Data lines past their hold time show the inverse, never the last value.
      pixel_data <= ~w;
      start_right <= 1'b0;
      start_left <= 1'b0;
      hold_cycles(1);
   endtask

   // One strobe level change; the bench issues one pulse per line
   task automatic strobe(input logic level);
      line_latch_strobe <= level;
      hold_cycles(20);
   endtask
endmodule

// ===== sim/tb_col_capture.sv
// Self-checking bench for the column data capture block.
// Assumes the design files are compiled first and a 200 MHz system clock.
`timescale 1ns/1ps
module tb_col_capture;
   import col_capture_pkg::*;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clk_sys, rst_n, hwrite, hreadyout, hresp, line_dir, hsel;
   logic [2:0] hsize; // Transfer size; only whole words are sent.
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic shift_clk, line_latch_strobe, src_right, src_left;
   logic right_start_pulse_out, right_start_pulse_oe, left_start_pulse_out, left_start_pulse_oe;
   logic [35:0] pixel_data;
   logic [479:0][5:0] column_outputs;
   logic [479:0] column_upper_set;
   logic [5:0] prev0; // Column 0 code of the line now on the outputs.
   int err_count, n_checks;
   // The start pins resolve to the driver whose enable is high.
   wire logic right_pin = right_start_pulse_oe ? right_start_pulse_out : src_right;
   wire logic left_pin = left_start_pulse_oe ? left_start_pulse_out : src_left;

   col_capture dut (.clk_sys(clk_sys), .rst_n(rst_n), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .shift_clk(shift_clk), .line_latch_strobe(line_latch_strobe),
      .pixel_data(pixel_data), .right_start_pulse_in(right_pin), .right_start_pulse_out(right_start_pulse_out),
      .right_start_pulse_oe(right_start_pulse_oe), .left_start_pulse_in(left_pin),
      .left_start_pulse_out(left_start_pulse_out), .left_start_pulse_oe(left_start_pulse_oe),
      .column_outputs(column_outputs), .column_upper_set(column_upper_set));
   pixel_source src (.clk_sys(clk_sys), .dir(line_dir), .shift_clk(shift_clk),
      .line_latch_strobe(line_latch_strobe), .pixel_data(pixel_data), .start_right(src_right),
      .start_left(src_left));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   // Counts a comparison and reports a mismatch.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Single AHB-Lite word write; waits out any wait state.
   task automatic ahb_wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      haddr <= a;
      hsel <= 1'b1;
      hsize <= 3'b010;
      hwrite <= 1'b1;
      htrans <= 2'b10;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
   endtask

   // Single AHB-Lite word read; data is taken at the closing edge of the data phase.
   task automatic ahb_rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      haddr <= a;
      hsel <= 1'b1;
      hsize <= 3'b010;
      hwrite <= 1'b0;
      htrans <= 2'b10;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      d = hrdata;
   endtask

   // Dot d of word k carries (6k+d+seed) mod 64, so column codes differ within any 64 adjacent columns.
   function automatic logic [35:0] word_of(input int k, input logic [5:0] seed);
      logic [35:0] w;
      for (int d = 0; d < 6; d++) w[6*d +: 6] = 6'(6 * k + d) + seed;
      return w;
   endfunction

   // Expected code of column index i after the direction mapping and group inversion.
   function automatic logic [5:0] exp_code(input int i, input logic dir, lo, hi, input logic [5:0] seed);
      int p;
      p = dir ? i : 479 - i;
      return (6'(p) + seed) ^ {6{(p % 6 < 3) ? lo : hi}};
   endfunction

   // Feeds a whole line; two leading edges without start must not capture.
   task automatic feed_line(input logic dir, input logic [5:0] seed);
      line_dir = dir;
      src.shift_word(36'hfff_fff_fff, 1'b0);
      src.shift_word(36'h0, 1'b0);
      for (int k = 0; k < 86; k++) begin
         src.shift_word(word_of(k, seed), k == 0);
         if (k >= 79 && k <= 81) begin
            // Sample late in the low phase, once the accepted edge has had its effect.
            src.hold_cycles(4);
            chk("start_out", 32'(k == 80), 32'(dir ? left_start_pulse_out : right_start_pulse_out));
            chk("start_oe", 32'h1, 32'(dir ? left_start_pulse_oe : right_start_pulse_oe));
         end
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Register reset values, read-back and an unmapped address.
   task automatic test_regs();
      logic [31:0] v;
      ahb_rd(32'h0, v);
      chk("ctrl_reset", 32'h1, v);
      chk("resp_okay", 32'h0, 32'(hresp));
      ahb_rd(32'h4, v);
      chk("status_reset", 32'h0, v);
      ahb_rd(32'h10, v);
      chk("unmapped", 32'h0, v);
      ahb_wr(32'h0, 32'h0e);
      ahb_rd(32'h0, v);
      chk("ctrl_rw", 32'h0e, v);
   endtask

   // Full line: capture, halt, strobe copy, then load on the falling edge.
   task automatic run_line(input logic dir, output_polarity_select, lo, hi, input logic [5:0] seed);
      logic [31:0] v;
      ahb_wr(32'h0, {27'h0, 1'b0, hi, lo, output_polarity_select, dir});
      feed_line(dir, seed);
      ahb_rd(32'h4, v);
      chk("halt_state", 32'h3, 32'(v[9:8]));
      src.strobe(1'b1);
      chk("not_yet_loaded", 32'(prev0), 32'(column_outputs[0]));
      ahb_rd(32'h4, v);
      chk("cleared", 32'h0, 32'(v[9:0]));
      src.strobe(1'b0);
      for (int i = 0; i < 480; i++) begin
         chk("code", 32'(exp_code(i, dir, lo, hi, seed)), 32'(column_outputs[i]));
         chk("upper_set", 32'((i % 2 == 0) ^ output_polarity_select), 32'(column_upper_set[i]));
      end
      // Read one odd-indexed column back through the select and read registers.
      ahb_wr(32'h8, 32'h7);
      ahb_rd(32'hc, v);
      chk("col_read", {25'h0, output_polarity_select, exp_code(7, dir, lo, hi, seed)}, v);
      prev0 = exp_code(0, dir, lo, hi, seed);
   endtask

   // Drain held: the FIFO fills and refuses, overflow is flagged, then cleared.
   task automatic test_overflow();
      logic [31:0] v;
      ahb_wr(32'h0, 32'h11);
      feed_line(1'b1, 6'h33);
      ahb_rd(32'h4, v);
      chk("overflow_set", 32'h1, 32'(v[12]));
      ahb_wr(32'h0, 32'h01);
      ahb_wr(32'h4, 32'h1000);
      ahb_rd(32'h4, v);
      chk("overflow_clear", 32'h0, 32'(v[12]));
      src.strobe(1'b1);
      src.strobe(1'b0);
   endtask

   // ----------------------------------------------------------------
   // Clock, reset, sequence and verdict
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // Prints the verdict and ends the run.
   task automatic complete_run();
      if (err_count == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   initial begin
      rst_n = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'b00;
      hsel = 1'b0;
      hsize = 3'b000;
      hwrite = 1'b0;
      line_dir = 1'b1;
      prev0 = 6'h0;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      // The pin synchronisers need a few cycles before the first pin event.
      repeat (4) @(posedge clk_sys);
      test_regs();
      run_line(1'b1, 1'b0, 1'b0, 1'b0, 6'h05);
      run_line(1'b0, 1'b1, 1'b1, 1'b0, 6'h2a);
      run_line(1'b1, 1'b1, 1'b0, 1'b1, 6'h11);
      test_overflow();
      complete_run();
   end

   // About 5,000 cycles are expected; this cuts a hang short.
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      complete_run();
   end
endmodule
